// File: bench/script_transfer_control_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Randomised bench
// ********************
module script_transfer_control_unit_test;
	import stc_pkg::*;
	logic        clk, rst, exec, carry, pnew, atn_n, tmode, ipwr, step;
	logic        flyclr, ack, irq_n, halted, illegal, busy, done;
	logic [2:0]  phase;
	logic [7:0]  fb, stat;
	logic [15:0] lf;
	logic [31:0] ipwd, w0, opd, ip, ra, opnd;
	int          error_cnt, compares;
	stc_instr_s  instr;
	stc_stream src_u (
		.i_target_mode(tmode), .i_word0(w0), .i_operand(opd), .o_instr(instr)
	);
	stc_transfer_ctrl dut_u (
		.i_clk(clk), .i_rst(rst), .i_exec(exec), .i_instr(instr),
		.i_carry(carry), .i_phase_latched(phase), .i_phase_new(pnew),
		.i_bus_attention_pin_n(atn_n), .i_target_mode(tmode),
		.i_first_received_byte(fb), .i_ip_wr(ipwr), .i_ip_wdata(ipwd),
		.i_ip_step(step), .i_fly_clr(flyclr), .i_irq_ack(ack), .o_ip(ip),
		.o_return_addr(ra), .o_instruction_operand(opnd),
		.o_interrupt_status(stat), .o_irq_n(irq_n), .o_halted(halted),
		.o_illegal(illegal), .o_busy(busy), .o_done(done)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd[15:0] = lf;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd[31:16] = lf;
	endfunction : rnd
	function automatic logic want(input logic [31:0] w);
		logic pc, dc;
		pc = tmode ? !atn_n : phase == w[26:24];
		dc = ((fb ^ w[7:0]) & ~w[15:8]) == 8'h00;
		if (w[21]) return carry == w[19];
		if (w[17] && w[18]) return w[19] ? pc && dc : !pc && !dc;
		if (w[17]) return pc == w[19];
		if (w[18]) return dc == w[19];
		return w[19];
	endfunction : want
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (e !== g) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic setip(input logic [31:0] v);
		@(negedge clk);
		ipwr = 1'b1;
		ipwd = v;
		@(negedge clk);
		ipwr = 1'b0;
	endtask : setip
	task automatic go();
		@(negedge clk);
		exec = 1'b1;
		@(negedge clk);
		exec = 1'b0;
	endtask : go
	task automatic waitdone();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40) begin
			error_cnt++;
			give_verdict();
		end
	endtask : waitdone
	task automatic one();
		logic [31:0] r, w, ip0, eip;
		logic        t, hit;
		r = rnd();
		setip(r & 32'hFFFFFFFC);
		r = rnd();
		w0 = {2'h2, r[29:17], 1'b0, r[15:0]};
		opd = rnd();
		r = rnd();
		{carry, tmode, atn_n, pnew} = {r[2:0], 1'b1};
		phase = r[3] ? w0[26:24] : r[6:4];
		fb = r[7] ? w0[7:0] ^ (r[15:8] & w0[15:8]) : r[15:8];
		// Synchronised pins need a few edges before they are trusted.
		repeat (3) @(negedge clk);
		w = instr.word0;
		ip0 = ip;
		t = want(w);
		hit = t && w[29:27] == 3'h3;
		eip = ip0;
		if (t && w[29:28] == 2'h0) begin
			eip = w[23] ? ip0 + {{8{opd[23]}}, opd[23:0]} : opd;
		end
		if (t && w[29:27] == 3'h2) begin
			eip = ra;
		end
		go();
		waitdone();
		chk("ip", eip, ip);
		if (t && w[29:27] == 3'h1) chk("ret", ip0, ra);
		chk("flags", {28'h0, !(hit || w[29]), hit && !w[20] || w[29], w[29],
			hit && w[20]}, {28'h0, irq_n, halted, illegal, stat[2]});
		chk("operand", opd, opnd);
		@(negedge clk);
		{ack, flyclr} = 2'h3;
		@(negedge clk);
		{ack, flyclr} = 2'h0;
	endtask : one
	initial begin
		{exec, carry, pnew, tmode, ipwr, step, flyclr, ack, atn_n, rst} = 10'h003;
		{phase, fb, ipwd, w0, opd} = 107'h0;
		lf = 16'hA78E;
		error_cnt = 0;
		compares = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		setip(32'h00001000);
		@(negedge clk);
		step = 1'b1;
		@(negedge clk);
		step = 1'b0;
		chk("step", 32'h00001004, ip);
		$display("step test done");
		repeat (300) one();
		$display("random test done");
		setip(32'h00002000);
		{pnew, tmode, phase} = 5'h00;
		w0 = 32'h800B0000;
		opd = 32'h00003000;
		repeat (3) @(negedge clk);
		go();
		repeat (6) @(negedge clk);
		chk("pending", 32'h1, {31'h0, busy});
		pnew = 1'b1;
		waitdone();
		chk("wait ip", 32'h00003000, ip);
		$display("wait test done");
		give_verdict();
	end
endmodule : script_transfer_control_unit_test
`default_nettype wire

// File: bench/stc_stream.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Instruction source
// ********************
module stc_stream
	import stc_pkg::*;
(
	input  wire logic        i_target_mode,
	input  wire logic [31:0] i_word0,
	input  wire logic [31:0] i_operand,
	output var  stc_instr_s  o_instr
);
	always_comb begin
		o_instr.word0   = i_word0;
		o_instr.operand = i_operand;
		if (i_target_mode) begin
			o_instr.word0[26:24] = 3'h0;
		end
		if (i_word0[21]) begin
			o_instr.word0[18:17] = 2'h0;
		end
	end
endmodule : stc_stream
`default_nettype wire

// File: bench/stc_transfer_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Port assertions
// ********************
module stc_transfer_ctrl_chk
	import stc_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_exec,
	input wire stc_instr_s  i_instr,
	input wire logic        i_ip_wr,
	input wire logic [31:0] i_ip_wdata,
	input wire logic        i_ip_step,
	input wire logic        i_irq_ack,
	input wire logic [31:0] o_ip,
	input wire logic [31:0] o_instruction_operand,
	input wire logic [7:0]  o_interrupt_status,
	input wire logic        o_irq_n,
	input wire logic        o_halted,
	input wire logic        o_illegal,
	input wire logic        o_busy,
	input wire logic        o_done
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_lat;
		i_exec && !o_busy && !o_halted && !i_instr.word0[16] |-> ##2 o_done;
	endproperty
	a_lat: assert property (p_lat) else $error("done late");
	property p_opnd;
		i_exec && !o_busy && !o_halted |=>
			o_instruction_operand == $past(i_instr.operand);
	endproperty
	a_opnd: assert property (p_opnd) else $error("operand lost");
	property p_wr;
		i_ip_wr |=> o_ip == $past(i_ip_wdata) && !o_halted;
	endproperty
	a_wr: assert property (p_wr) else $error("pointer write");
	property p_halt;
		o_halted && !i_ip_wr |=> o_halted;
	endproperty
	a_halt: assert property (p_halt) else $error("halt left");
	property p_ack;
		i_irq_ack && !o_busy |=> o_irq_n && !o_illegal;
	endproperty
	a_ack: assert property (p_ack) else $error("request held");
	property p_fly;
		$rose(o_interrupt_status[2]) |-> o_done && !o_halted && !o_irq_n;
	endproperty
	a_fly: assert property (p_fly) else $error("fly flag");
	property p_ill;
		$rose(o_illegal) |-> o_halted && !o_irq_n && o_done;
	endproperty
	a_ill: assert property (p_ill) else $error("illegal op");
	property p_idle;
		!o_busy && !i_exec && !i_ip_step && !i_ip_wr |=> $stable(o_ip);
	endproperty
	a_idle: assert property (p_idle) else $error("pointer moved");
endmodule : stc_transfer_ctrl_chk
bind stc_transfer_ctrl stc_transfer_ctrl_chk chk_u (.*);
`default_nettype wire

// File: inc/stc_map.svh
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ********************************************************************
// Instruction field positions
// ********************************************************************
`define STC_TYPE_HI      31
`define STC_TYPE_LO      30
`define STC_OPC_HI       29
`define STC_OPC_LO       27
`define STC_PHASE_HI     26
`define STC_PHASE_LO     24
`define STC_REL_BIT      23
`define STC_CARRY_BIT    21
`define STC_FLY_BIT      20
`define STC_TF_BIT       19
`define STC_CDATA_BIT    18
`define STC_CPHASE_BIT   17
`define STC_WAIT_BIT     16
`define STC_MASK_HI      15
`define STC_MASK_LO      8
`define STC_DATA_HI      7
`define STC_DATA_LO      0
`define STC_OFS_HI       23

// ********************************************************************
// Codes and reset values
// ********************************************************************
`define STC_TYPE_XFER    2'h2
`define STC_OPC_JUMP     3'h0
`define STC_OPC_CALL     3'h1
`define STC_OPC_RET      3'h2
`define STC_OPC_INT      3'h3
`define STC_INTERRUPT_STATUS_REGISTER_FLY    2
`define STC_RST_WORD     32'h00000000
`define STC_RST_INTERRUPT_STATUS_REGISTER    8'h00

`endif

// File: inc/stc_pkg.sv
package stc_pkg;

	typedef enum logic [2:0] {
		STC_JUMP,
		STC_CALL,
		STC_RET,
		STC_INT,
		STC_RSVD
	} stc_op_e;

	typedef struct packed {
		logic [31:0] word0;
		logic [31:0] operand;
	} stc_instr_s;

	typedef struct packed {
		logic       carry;
		logic [2:0] phase;
		logic       phase_new;
		logic       atn_n;
		logic       target_mode;
		logic [7:0] first_byte;
	} stc_cond_s;

endpackage : stc_pkg

// File: verilog/stc_cond.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module stc_cond
	import stc_pkg::*;
(
	input  wire logic [31:0] i_word0,
	input  wire stc_cond_s   i_cond,
	output var  logic        o_take
);

	logic [7:0] diff;
	logic       ph_res;
	logic       dt_res;
	logic       tf;
	logic       use_ph;
	logic       use_dt;

	// ****************************************************************
	// Condition evaluation
	// ****************************************************************
	always_comb begin
		tf     = i_word0[`STC_TF_BIT];
		use_ph = i_word0[`STC_CPHASE_BIT];
		use_dt = i_word0[`STC_CDATA_BIT];
		// Masked bits are forced equal. [RULE23] [RULE24]
		diff   = (i_cond.first_byte ^ i_word0[`STC_DATA_HI:`STC_DATA_LO])
			& ~i_word0[`STC_MASK_HI:`STC_MASK_LO];
		dt_res = (diff == 8'h00); // [RULE18]
		if (i_cond.target_mode) begin
			ph_res = ~i_cond.atn_n; // [RULE20]
		end else begin
			ph_res = (i_cond.phase ==
				i_word0[`STC_PHASE_HI:`STC_PHASE_LO]); // [RULE11] [RULE19]
		end
		if (i_word0[`STC_CARRY_BIT]) begin
			o_take = (i_cond.carry == tf); // [RULE15] [RULE16]
		end else if (use_ph && use_dt) begin
			o_take = (ph_res == tf) && (dt_res == tf); // [RULE17]
		end else if (use_ph) begin
			o_take = (ph_res == tf); // [RULE16]
		end else if (use_dt) begin
			o_take = (dt_res == tf); // [RULE16]
		end else begin
			// No test selected: unconditional on true, never on false.
			o_take = tf;
		end
	end

endmodule : stc_cond

`default_nettype wire

// File: verilog/stc_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module stc_decode
	import stc_pkg::*;
(
	input  wire logic [31:0] i_word0,
	output var  stc_op_e     o_op,
	output var  logic        o_is_xfer
);

	// ****************************************************************
	// Opcode decode
	// ****************************************************************
	always_comb begin
		o_is_xfer = (i_word0[`STC_TYPE_HI:`STC_TYPE_LO] == `STC_TYPE_XFER);
		case (i_word0[`STC_OPC_HI:`STC_OPC_LO])
			`STC_OPC_JUMP: o_op = STC_JUMP; // [RULE1]
			`STC_OPC_CALL: o_op = STC_CALL; // [RULE1]
			`STC_OPC_RET:  o_op = STC_RET; // [RULE1]
			`STC_OPC_INT:  o_op = STC_INT; // [RULE1]
			default:       o_op = STC_RSVD; // [RULE1]
		endcase
	end

endmodule : stc_decode

`default_nettype wire

// File: verilog/stc_transfer_ctrl.sv
//
// Overview of operation
// RULE1: Opcode 000 jump, 001 call, 010 return, 011 interrupt, 1xx reserved.
// RULE2: Taken jump loads the operand into the instruction pointer.
// RULE3: Untaken jump, call or return leaves the pointer unchanged.
// RULE4: Call saves the pointer into a single return register; no nesting.
// RULE5: Taken return reloads the pointer from the return register.
// RULE6: Return without prior call is not tracked and raises nothing.
// RULE7: Taken interrupt asserts the active-low interrupt request.
// RULE8: Interrupt keeps its 32-bit operand readable as a status vector.
// RULE9: Halting interrupt stops until the host writes the pointer.
// RULE10: On-the-fly interrupt keeps running and sets status bit 2.
// RULE11: Phase field compares against phase lines latched at request.
// RULE12: Source clears phase field in target mode.
// RULE13: Relative mode adds sign-extended 24-bit offset to next pointer.
// RULE14: Relative mode only for jump and call.
// RULE15: Carry test uses ALU carry; not mixed with data or phase.
// RULE16: Branch when compare result equals the true/false bit.
// RULE17: With both compares, both must equal the true/false bit.
// RULE18: Data compare tests the first received byte against the value.
// RULE19: Initiator phase compare is true when latched phase matches.
// RULE20: Target phase compare tests the attention line instead.
// RULE21: Wait bit delays compares until a new unserviced phase.
// RULE22: Wait bit clear compares at once.
// RULE23: Set mask bits exclude received byte bits from the compare.
// RULE24: Compare value is the low byte of the first word.
// RULE25: Reserved opcode halts and flags an illegal instruction.
//
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module stc_transfer_ctrl
	import stc_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_exec,
	input  wire stc_instr_s  i_instr,
	input  wire logic        i_carry,
	input  wire logic [2:0]  i_phase_latched,
	input  wire logic        i_phase_new,
	input  wire logic        i_bus_attention_pin_n,
	input  wire logic        i_target_mode,
	input  wire logic [7:0]  i_first_received_byte,
	input  wire logic        i_ip_wr,
	input  wire logic [31:0] i_ip_wdata,
	input  wire logic        i_ip_step,
	input  wire logic        i_fly_clr,
	input  wire logic        i_irq_ack,
	output logic [31:0]      o_ip,
	output logic [31:0]      o_return_addr,
	output logic [31:0]      o_instruction_operand,
	output logic [7:0]       o_interrupt_status,
	output logic             o_irq_n,
	output logic             o_halted,
	output logic             o_illegal,
	output logic             o_busy,
	output logic             o_done
);

	// ****************************************************************
	// Synchronisers for bus pins
	// ****************************************************************
	logic [2:0] ph_s1_q;
	logic [2:0] ph_s2_q;
	logic       new_s1_q;
	logic       new_s2_q;
	logic       atn_s1_q;
	logic       atn_s2_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ph_s1_q  <= 3'h0;
			ph_s2_q  <= 3'h0;
			new_s1_q <= 1'b0;
			new_s2_q <= 1'b0;
			atn_s1_q <= 1'b1;
			atn_s2_q <= 1'b1;
		end else begin
			ph_s1_q  <= i_phase_latched;
			ph_s2_q  <= ph_s1_q;
			new_s1_q <= i_phase_new;
			new_s2_q <= new_s1_q;
			atn_s1_q <= i_bus_attention_pin_n;
			atn_s2_q <= atn_s1_q;
		end
	end

	// ****************************************************************
	// Execution state
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_HALT
	} stc_state_e;

	stc_state_e  state_q;
	stc_instr_s  instr_q;
	stc_op_e     op;
	logic        is_xfer;
	logic        take;
	logic        fire;
	logic        wait_bit;
	stc_cond_s   cond;
	logic [31:0] rel_tgt;
	logic [31:0] tgt;

	stc_decode u_dec (
		.i_word0   (instr_q.word0),
		.o_op      (op),
		.o_is_xfer (is_xfer)
	);

	assign cond.carry       = i_carry;
	assign cond.phase       = ph_s2_q;
	assign cond.phase_new   = new_s2_q;
	assign cond.atn_n       = atn_s2_q;
	assign cond.target_mode = i_target_mode;
	assign cond.first_byte  = i_first_received_byte;

	stc_cond u_cond (
		.i_word0 (instr_q.word0),
		.i_cond  (cond),
		.o_take  (take)
	);

	// A carry test never waits; only phase and data compares do.
	assign wait_bit = instr_q.word0[`STC_WAIT_BIT]
		& ~instr_q.word0[`STC_CARRY_BIT]
		& (instr_q.word0[`STC_CPHASE_BIT] | instr_q.word0[`STC_CDATA_BIT]);
	// Evaluate once the instruction is held and, if asked, a fresh phase.
	assign fire = (state_q == ST_WAIT) && (!wait_bit || new_s2_q); // [RULE21] [RULE22]

	assign rel_tgt = o_ip + {{8{instr_q.operand[`STC_OFS_HI]}},
		instr_q.operand[`STC_OFS_HI:0]}; // [RULE13]
	assign tgt = (instr_q.word0[`STC_REL_BIT] &&
		(op == STC_JUMP || op == STC_CALL)) ? rel_tgt : instr_q.operand; // [RULE14]

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (i_exec) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (fire) begin
						if (!is_xfer || op == STC_RSVD) begin
							state_q <= ST_HALT; // [RULE25]
						end else if (op == STC_INT && take &&
							!instr_q.word0[`STC_FLY_BIT]) begin
							state_q <= ST_HALT; // [RULE9]
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_HALT: begin
					if (i_ip_wr) begin
						state_q <= ST_IDLE; // [RULE9]
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			instr_q <= '0;
		end else if (state_q == ST_IDLE && i_exec) begin
			instr_q <= i_instr;
		end
	end

	// ****************************************************************
	// Instruction pointer and return address
	// ****************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ip <= `STC_RST_WORD;
		end else if (i_ip_wr) begin
			o_ip <= i_ip_wdata;
		end else if (fire && is_xfer && take) begin
			case (op)
				STC_JUMP: o_ip <= tgt; // [RULE2]
				STC_CALL: o_ip <= tgt; // [RULE2]
				STC_RET:  o_ip <= o_return_addr; // [RULE5] [RULE6]
				default:  o_ip <= o_ip; // [RULE3]
			endcase
		end else if (i_ip_step && state_q == ST_IDLE) begin
			// Sequencer advances past each fetched word. [RULE3]
			o_ip <= o_ip + 32'h00000004;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_return_addr <= `STC_RST_WORD;
		end else if (fire && is_xfer && take && op == STC_CALL) begin
			// One entry only: a second call overwrites it. [RULE4]
			o_return_addr <= o_ip;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_instruction_operand <= `STC_RST_WORD;
		end else if (state_q == ST_IDLE && i_exec) begin
			o_instruction_operand <= i_instr.operand; // [RULE8]
		end
	end

	// ****************************************************************
	// Interrupts and status
	// ****************************************************************
	logic int_hit;
	logic fly_hit;

	assign int_hit = fire && is_xfer && op == STC_INT && take;
	assign fly_hit = int_hit && instr_q.word0[`STC_FLY_BIT];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_interrupt_status <= `STC_RST_INTERRUPT_STATUS_REGISTER;
		end else if (fly_hit) begin
			// Set wins over a clear in the same cycle. [RULE10]
			o_interrupt_status[`STC_INTERRUPT_STATUS_REGISTER_FLY] <= 1'b1;
		end else if (i_fly_clr) begin
			o_interrupt_status[`STC_INTERRUPT_STATUS_REGISTER_FLY] <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_n <= 1'b1;
		end else if (int_hit || (fire && (!is_xfer || op == STC_RSVD))) begin
			o_irq_n <= 1'b0; // [RULE7] [RULE25]
		end else if (i_irq_ack) begin
			o_irq_n <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_illegal <= 1'b0;
		end else if (fire && (!is_xfer || op == STC_RSVD)) begin
			o_illegal <= 1'b1; // [RULE25]
		end else if (i_irq_ack) begin
			o_illegal <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_halted <= 1'b0;
			o_busy   <= 1'b0;
			o_done   <= 1'b0;
		end else begin
			o_halted <= (state_q == ST_HALT && !i_ip_wr) ||
				(fire && (!is_xfer || op == STC_RSVD ||
				(int_hit && !instr_q.word0[`STC_FLY_BIT]))); // [RULE9]
			o_busy   <= (state_q == ST_IDLE && i_exec) ||
				(state_q == ST_WAIT && !fire);
			o_done   <= fire;
		end
	end

endmodule : stc_transfer_ctrl

`default_nettype wire
